// *** hdl/tdma_pkg.sv ***
// constants and types shared by the transmit descriptor engine
package tdma_pkg;
    localparam int NUM_Q = 2;
    localparam int ADDR_W = 30;
    localparam int DATA_W = 32;
    localparam int LEN_W = 16;
    localparam int BYTE_W = 8;
    localparam int DMAP_W = 58;
    localparam int RX_Q_LO = 50;
    localparam int RX_Q_N = 8;
    localparam int REC_EOP_BIT = 31;
    localparam int REC_IND_BIT = 30;
    localparam int BUF_LAST_POS = 8;
    localparam int BUF_IND_POS = 9;
    localparam int BUF_W = 10;
    localparam logic [ADDR_W-1:0] WORD_STEP = 30'h0000_0001;
    localparam logic [ADDR_W-1:0] REC_STEP = 30'h0000_0002;
    localparam logic [1:0] LANE_LAST = 2'h3;
    localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
    localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0000;

    typedef logic [ADDR_W-1:0] tdma_wptr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_QFETCH = 3'h1,
        ST_REC0 = 3'h3,
        ST_REC1 = 3'h2,
        ST_DATA = 3'h6
    } tdma_state_e;
endpackage: tdma_pkg

// *** hdl/tdma_buf_if.sv ***
// handshake carrier between the engine and its two-entry buffer
`timescale 1ns/100ps
`default_nettype none
interface tdma_buf_if #(parameter int W = 10);
    logic [W-1:0] inData;
    logic inValid;
    logic inReady;
    logic [W-1:0] outData;
    logic outValid;
    logic outReady;
    modport fill (output inData, output inValid, input inReady,
        input outData, input outValid, output outReady);
    modport store (input inData, input inValid, output inReady,
        output outData, output outValid, input outReady);
endinterface: tdma_buf_if
`default_nettype wire

// *** hdl/tdma_pair_buf.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module tdma_pair_buf #(parameter int W = 10) (
    input wire logic clk_sys,
    input wire logic rst_n,
    tdma_buf_if.store bus
);
    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic v0;
    logic v1;
    logic push;
    logic pop;

    assign push = bus.inValid && !v1;
    assign pop = v0 && bus.outReady;
    assign bus.inReady = !v1;
    assign bus.outValid = v0;
    assign bus.outData = slot0;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            v0 <= 1'b0;
            v1 <= 1'b0;
            slot0 <= '0;
            slot1 <= '0;
        end else if (push && pop) begin
            if (v1) begin
                slot0 <= slot1;
                slot1 <= bus.inData;
            end else begin
                slot0 <= bus.inData;
            end
        end else if (pop) begin
            slot0 <= slot1;
            v0 <= v1;
            v1 <= 1'b0;
        end else if (push) begin
            if (!v0) begin
                slot0 <= bus.inData;
                v0 <= 1'b1;
            end else begin
                slot1 <= bus.inData;
                v1 <= 1'b1;
            end
        end
    end
endmodule: tdma_pair_buf
`default_nettype wire

// *** hdl/tdma_engine.sv ***
// supervisor transmit descriptor engine with receive queue map
`timescale 1ns/100ps
`default_nettype none
module tdma_engine (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [tdma_pkg::NUM_Q-1:0] txEnable,
    input wire tdma_pkg::tdma_wptr_t [tdma_pkg::NUM_Q-1:0] startPtr,
    input wire tdma_pkg::tdma_wptr_t [tdma_pkg::NUM_Q-1:0] endPtr,
    input wire tdma_pkg::tdma_wptr_t [tdma_pkg::NUM_Q-1:0] lastPtr,
    output logic memRdReq,
    output tdma_pkg::tdma_wptr_t memRdAddr,
    input wire logic memRdAck,
    input wire logic [tdma_pkg::DATA_W-1:0] memRdData,
    output logic [tdma_pkg::BYTE_W-1:0] pktData,
    output logic pktLast,
    output logic pktValid,
    input wire logic pktReady,
    output logic txIndicate,
    output logic engineBusy,
    output logic activeQueue,
    input wire logic [tdma_pkg::DMAP_W-1:0] destMap,
    output logic [tdma_pkg::RX_Q_N-1:0] rxRingHit
);
    import tdma_pkg::*;

    tdma_state_e state;
    tdma_wptr_t fetchPtr [NUM_Q];
    logic curQ;
    tdma_wptr_t descAddr;
    logic [DATA_W-1:0] segAddr;
    logic [LEN_W-1:0] remLen;
    logic eopFlag;
    logic indFlag;
    logic [DATA_W-1:0] dataWord;
    logic wordValid;
    logic [NUM_Q-1:0] pending;
    logic memAck;
    logic emit;
    logic lastByte;
    logic [LEN_W-1:0] recLen;
    logic [BYTE_W-1:0] curByte;

    tdma_buf_if #(.W(BUF_W)) bufIf ();

    tdma_pair_buf #(.W(BUF_W)) u_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(bufIf.store)
    );

    function automatic tdma_wptr_t nextPtr(input tdma_wptr_t p,
        input tdma_wptr_t s, input tdma_wptr_t e);
        nextPtr = (p == e) ? s : p + WORD_STEP;
    endfunction: nextPtr

    // queue holds work while its fetch point has not passed last entry
    always_comb begin
        for (int q = 0; q < NUM_Q; q++) begin
            pending[q] = txEnable[q] && (fetchPtr[q] !=
                nextPtr(lastPtr[q], startPtr[q], endPtr[q]));
        end
    end

    assign memAck = memRdReq && memRdAck;
    assign lastByte = (remLen == LEN_ONE);
    assign recLen = memRdData[LEN_W-1:0];
    // little-endian byte lane of the current word
    assign curByte = dataWord[{segAddr[1:0], 3'h0} +: BYTE_W];
    assign emit = (state == ST_DATA) && wordValid && bufIf.inReady;

    assign bufIf.inValid = (state == ST_DATA) && wordValid;
    assign bufIf.inData = {indFlag && lastByte, eopFlag && lastByte,
        curByte};
    assign bufIf.outReady = pktReady;

    assign pktData = bufIf.outData[BYTE_W-1:0];
    assign pktLast = bufIf.outData[BUF_LAST_POS];
    assign pktValid = bufIf.outValid;
    assign activeQueue = curQ;

    // per-queue fetch positions, kept across preemption
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int q = 0; q < NUM_Q; q++) begin
                fetchPtr[q] <= '0;
            end
        end else begin
            for (int q = 0; q < NUM_Q; q++) begin
                if (!txEnable[q]) begin
                    fetchPtr[q] <= startPtr[q];
                end else if (state == ST_QFETCH && memAck &&
                    curQ == 1'(q)) begin
                    fetchPtr[q] <= nextPtr(fetchPtr[q], startPtr[q],
                        endPtr[q]);
                end
            end
        end
    end

    // descriptor walk and memory read sequencing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            curQ <= 1'b0;
            memRdReq <= 1'b0;
            memRdAddr <= '0;
            descAddr <= '0;
            segAddr <= '0;
            remLen <= '0;
            eopFlag <= 1'b0;
            indFlag <= 1'b0;
            dataWord <= '0;
            wordValid <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (pending[1]) begin
                        curQ <= 1'b1;
                        memRdAddr <= fetchPtr[1];
                        memRdReq <= 1'b1;
                        state <= ST_QFETCH;
                    end else if (pending[0]) begin
                        curQ <= 1'b0;
                        memRdAddr <= fetchPtr[0];
                        memRdReq <= 1'b1;
                        state <= ST_QFETCH;
                    end
                end
                ST_QFETCH: begin
                    if (memAck) begin
                        descAddr <= memRdData[DATA_W-1:2];
                        memRdAddr <= memRdData[DATA_W-1:2];
                        state <= ST_REC0;
                    end
                end
                ST_REC0: begin
                    if (memAck) begin
                        segAddr <= memRdData;
                        memRdAddr <= descAddr + WORD_STEP;
                        state <= ST_REC1;
                    end
                end
                ST_REC1: begin
                    if (memAck) begin
                        remLen <= recLen;
                        eopFlag <= memRdData[REC_EOP_BIT];
                        indFlag <= memRdData[REC_IND_BIT];
                        descAddr <= descAddr + REC_STEP;
                        wordValid <= 1'b0;
                        if (recLen != LEN_ZERO) begin
                            memRdAddr <= segAddr[DATA_W-1:2];
                            state <= ST_DATA;
                        end else if (memRdData[REC_EOP_BIT]) begin
                            memRdReq <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            memRdAddr <= descAddr + REC_STEP;
                            state <= ST_REC0;
                        end
                    end
                end
                ST_DATA: begin
                    if (memAck) begin
                        dataWord <= memRdData;
                        wordValid <= 1'b1;
                        memRdReq <= 1'b0;
                    end
                    if (emit) begin
                        segAddr <= segAddr + DATA_W'(1);
                        remLen <= remLen - LEN_ONE;
                        if (lastByte) begin
                            wordValid <= 1'b0;
                            if (eopFlag) begin
                                state <= ST_IDLE;
                            end else begin
                                memRdReq <= 1'b1;
                                memRdAddr <= descAddr;
                                state <= ST_REC0;
                            end
                        end else if (segAddr[1:0] == LANE_LAST) begin
                            wordValid <= 1'b0;
                            memRdReq <= 1'b1;
                            memRdAddr <= segAddr[DATA_W-1:2] + WORD_STEP;
                        end
                    end
                end
            endcase
        end
    end

    // notify the cycle after the flagged segment's final byte leaves the buffer to the sink
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txIndicate <= 1'b0;
        end else begin
            txIndicate <= bufIf.outValid && pktReady &&
                bufIf.outData[BUF_IND_POS];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            engineBusy <= 1'b0;
        end else begin
            engineBusy <= (state != ST_IDLE);
        end
    end

    // supervisor receive queues, one ring each
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxRingHit <= '0;
        end else begin
            rxRingHit <= destMap[RX_Q_LO +: RX_Q_N];
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_recHead;
        state == ST_REC0 && memAck;
    endsequence

    sequence s_lastOfPkt;
        emit && lastByte && eopFlag;
    endsequence

    property p_prio;
        state == ST_IDLE && pending[1] |=> state == ST_QFETCH && curQ;
    endproperty
    a_prio: assert property (p_prio)
        else $error("queue one not preferred");

    property p_resume;
        state == ST_IDLE && (|pending) |=> memRdReq &&
            memRdAddr == (curQ ? $past(fetchPtr[1]) : $past(fetchPtr[0]));
    endproperty
    a_resume: assert property (p_resume)
        else $error("fetch did not resume at saved point");

    property p_wrap;
        state == ST_QFETCH && memAck && memRdAddr == endPtr[curQ] &&
            txEnable[curQ] |=> fetchPtr[curQ] == $past(startPtr[curQ]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("no wrap to base after end entry");

    property p_hold;
        memRdReq && !memRdAck |=> memRdReq && $stable(memRdAddr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read request dropped or moved");

    property p_recPair;
        s_recHead |=> state == ST_REC1 &&
            memRdAddr == $past(descAddr) + WORD_STEP;
    endproperty
    a_recPair: assert property (p_recPair)
        else $error("record second word not next");

    property p_eop;
        s_lastOfPkt |=> state == ST_IDLE && !memRdReq;
    endproperty
    a_eop: assert property (p_eop)
        else $error("descriptor walk did not stop at end flag");

    property p_notify;
        bufIf.outValid && pktReady && bufIf.outData[BUF_IND_POS]
            |=> txIndicate ##1 !txIndicate || pktValid;
    endproperty
    a_notify: assert property (p_notify)
        else $error("notify missing after stored segment");

    property p_rxMap;
        ##1 rxRingHit == $past(destMap[RX_Q_LO +: RX_Q_N]);
    endproperty
    a_rxMap: assert property (p_rxMap)
        else $error("receive queue map wrong");

    property p_gather;
        emit && !lastByte |=> segAddr == $past(segAddr) + DATA_W'(1) &&
            remLen == $past(remLen) - LEN_ONE;
    endproperty
    a_gather: assert property (p_gather)
        else $error("segment bytes not contiguous");

    property p_reload;
        !txEnable[0] && !txEnable[1] |=> fetchPtr[0] == $past(startPtr[0])
            && fetchPtr[1] == $past(startPtr[1]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("disabled queue did not reload its base");

    property p_entryToDesc;
        state == ST_QFETCH && memAck |=> state == ST_REC0 &&
            memRdAddr == $past(memRdData[DATA_W-1:2]);
    endproperty
    a_entryToDesc: assert property (p_entryToDesc)
        else $error("descriptor address not taken from entry");

    property p_segStart;
        state == ST_REC1 && memAck && recLen != LEN_ZERO |=>
            state == ST_DATA && memRdReq &&
            memRdAddr == $past(segAddr[DATA_W-1:2]);
    endproperty
    a_segStart: assert property (p_segStart)
        else $error("segment read not at record address");

    property p_lastFlag;
        emit |-> bufIf.inData[BUF_LAST_POS] == (eopFlag && lastByte);
    endproperty
    a_lastFlag: assert property (p_lastFlag)
        else $error("packet end marked on wrong byte");

    property p_notifyFlag;
        txIndicate |-> $past(pktValid && pktReady &&
            bufIf.outData[BUF_IND_POS]);
    endproperty
    a_notifyFlag: assert property (p_notifyFlag)
        else $error("notify without a stored flagged byte");

    property p_idleHold;
        state == ST_IDLE && !(|pending) |=> state == ST_IDLE && !memRdReq;
    endproperty
    a_idleHold: assert property (p_idleHold)
        else $error("fetch started with no pending entry");

    property p_keepQueue;
        state != ST_IDLE |=> $stable(curQ);
    endproperty
    a_keepQueue: assert property (p_keepQueue)
        else $error("queue switched inside a packet");
endmodule: tdma_engine
`default_nettype wire

// *** testbench/tdma_mem_model.sv ***
// supervisor memory model answering the engine's word reads
`timescale 1ns/100ps
`default_nettype none
module tdma_mem_model (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic memRdReq,
    input wire tdma_pkg::tdma_wptr_t memRdAddr,
    output logic memRdAck,
    output logic [tdma_pkg::DATA_W-1:0] memRdData
);
    import tdma_pkg::*;
    logic [DATA_W-1:0] words [0:255];
    logic [1:0] waitCnt;
    initial begin
        memRdAck = 1'b0;
        memRdData = 32'h0000_0000;
        waitCnt = 2'h0;
    end
    always @(posedge clk_sys) begin
        memRdAck <= 1'b0;
        // bus released: data keeps changing
        memRdData <= ~memRdData;
        if (memRdReq === 1'b1 && !memRdAck) begin
            if (!slow || waitCnt == 2'h3) begin
                memRdAck <= 1'b1;
                memRdData <= words[memRdAddr[7:0]];
                waitCnt <= 2'h0;
            end else begin
                waitCnt <= waitCnt + 2'h1;
            end
        end
    end
endmodule: tdma_mem_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the transmit descriptor engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tdma_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [NUM_Q-1:0] txEnable = 2'h0;
    tdma_wptr_t [NUM_Q-1:0] startPtr = {30'h0000_0018, 30'h0000_0010};
    tdma_wptr_t [NUM_Q-1:0] endPtr = {30'h0000_0019, 30'h0000_0013};
    tdma_wptr_t [NUM_Q-1:0] lastPtr = {30'h0000_0019, 30'h0000_0013};
    logic memRdReq, memRdAck, pktLast, pktValid, txIndicate, engineBusy;
    logic activeQueue;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic pktReady = 1'b0;
    tdma_wptr_t memRdAddr;
    logic [DATA_W-1:0] memRdData;
    logic [BYTE_W-1:0] pktData;
    logic [DMAP_W-1:0] destMap = 58'h0;
    logic [RX_Q_N-1:0] rxRingHit;
    logic [8:0] gotQ [$];
    logic [8:0] expQ [$];
    int errors = 0;
    int n_checks = 0;
    int nInd = 0;
    int expInd = 0;
    int cyc = 0;
    logic [1:0] qTag = 2'h1;

    always #20 clk_sys = ~clk_sys;

    tdma_engine dut (.clk_sys(clk_sys), .rst_n(rst_n), .txEnable(txEnable),
        .startPtr(startPtr), .endPtr(endPtr), .lastPtr(lastPtr),
        .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdAck(memRdAck),
        .memRdData(memRdData), .pktData(pktData), .pktLast(pktLast),
        .pktValid(pktValid), .pktReady(pktReady), .txIndicate(txIndicate),
        .engineBusy(engineBusy), .activeQueue(activeQueue),
        .destMap(destMap), .rxRingHit(rxRingHit));

    tdma_mem_model mem (.clk_sys(clk_sys), .slow(slow),
        .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdAck(memRdAck),
        .memRdData(memRdData));

    // packet sink with optional stalls
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        pktReady <= !stall || (cyc % 3 == 0);
        if (pktValid === 1'b1 && pktReady) begin
            gotQ.push_back({pktLast, pktData});
        end
        if (txIndicate === 1'b1) begin
            nInd <= nInd + 1;
        end
        // queue served while its entry word is read
        if (memRdReq === 1'b1 && memRdAck === 1'b1) begin
            if (memRdAddr == startPtr[1]) begin
                qTag[1] <= activeQueue;
            end
            if (memRdAddr == 30'h0000_0012) begin
                qTag[0] <= activeQueue;
            end
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] want,
        input string what);
        n_checks++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h want %h",
                $time, what, seen, want);
        end
    endtask: check

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask: tally_and_finish

    // queue entry at word e pointing at descriptor word d
    task entry(input int e, input int d);
        mem.words[e] = {30'(d), 2'h3};
    endtask: entry

    task rec(input int w, input int seg, input int len, input bit eop,
        input bit ind);
        mem.words[w] = 32'(seg);
        mem.words[w+1] = {eop, ind, 14'h0, 16'(len)};
        for (int i = 0; i < len; i++) begin
            expQ.push_back({eop && i == len - 1, 8'(seg + i)});
        end
        if (ind && len > 0) begin
            expInd++;
        end
    endtask: rec

    task wait_bytes(input int n);
        int k;
        k = 0;
        // sampled off the edge so the sink has settled
        while (gotQ.size() < n && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        if (gotQ.size() < n) begin
            check(32'h0, 32'h1, "timeout bytes");
            tally_and_finish();
        end
        @(posedge clk_sys);
    endtask: wait_bytes

    task wait_idle;
        int k;
        k = 0;
        while (engineBusy !== 1'b0 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        if (engineBusy !== 1'b0) begin
            check(32'h0, 32'h1, "timeout idle");
            tally_and_finish();
        end
        @(posedge clk_sys);
    endtask: wait_idle

    task drain(input string name);
        wait_bytes(expQ.size());
        wait_idle();
        repeat (4) @(posedge clk_sys);
        check(32'(gotQ.size()), 32'(expQ.size()), "count");
        for (int i = 0; i < expQ.size() && i < gotQ.size(); i++) begin
            check(32'(gotQ[i]), 32'(expQ[i]), "byte");
        end
        check(32'(nInd), 32'(expInd), "notify");
        $display("test %s done", name);
    endtask: drain

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem.words[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
        end
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        txEnable <= 2'h3;
        // two-record packet, unaligned first segment
        entry(16, 64);
        rec(64, 'h203, 3, 1'b0, 1'b1);
        rec(66, 'h210, 2, 1'b1, 1'b0);
        @(posedge clk_sys);
        lastPtr[0] <= 30'h0000_0010;
        drain("gather");
        slow <= 1'b1;
        stall <= 1'b1;
        entry(17, 68);
        rec(68, 'h220, 4, 1'b1, 1'b1);
        entry(18, 70);
        rec(70, 'h231, 1, 1'b1, 1'b0);
        entry(19, 72);
        rec(72, 'h240, 5, 1'b1, 1'b1);
        lastPtr[0] <= 30'h0000_0013;
        drain("advance");
        entry(16, 74);
        rec(74, 'h250, 2, 1'b1, 1'b0);
        lastPtr[0] <= 30'h0000_0010;
        drain("wrap");
        // high queue arrives while a low packet is in flight
        entry(17, 76);
        entry(18, 78);
        entry(24, 80);
        rec(76, 'h260, 8, 1'b1, 1'b0);
        rec(80, 'h2A0, 2, 1'b1, 1'b1);
        rec(78, 'h280, 3, 1'b1, 1'b0);
        lastPtr[0] <= 30'h0000_0012;
        wait_bytes(gotQ.size() + 1);
        lastPtr[1] <= 30'h0000_0018;
        drain("priority");
        check(32'(qTag), 32'h2, "queue order");
        for (int i = 0; i < 8; i++) begin
            destMap <= (58'h1 << (50 + i)) | 58'h3_FFFF_FFFF_FFFF;
            repeat (2) @(posedge clk_sys);
            check(32'(rxRingHit), 32'(8'h1 << i), "ring");
        end
        $display("test ringmap done");
        tally_and_finish();
    end
endmodule: tb_top
`default_nettype wire
